/* verilog/wdtsm_consts.svh */
`ifndef WDTSM_CONSTS_SVH
`define WDTSM_CONSTS_SVH
// ==========================================
// timing
`define WDTSM_CLK_PERIOD_NS 40
`define WDTSM_TICK_NS 1000000
`define WDTSM_TICK_CYCLES (`WDTSM_TICK_NS / `WDTSM_CLK_PERIOD_NS)
`define WDTSM_RST_CYCLES 3'h4
// ==========================================
// counter and period select
`define WDTSM_CNT_W 19
`define WDTSM_PS_W 5
`define WDTSM_PS_MAX 5'h12
`define WDTSM_PS_RESET 5'h0b
`define WDTSM_SWEN_RESET 1'h0
`define WDTSM_CNT_ONE 19'h0_0001
`define WDTSM_CNT_ZERO 19'h0_0000
// ==========================================
// configuration enable field codes
`define WDTSM_CFG_ALWAYS 2'h3
`define WDTSM_CFG_NOSLEEP 2'h2
`define WDTSM_CFG_SOFT 2'h1
`define WDTSM_CFG_OFF 2'h0
// ==========================================
// register map, byte addresses
`define WDTSM_ADR_CTRL 8'h00
`define WDTSM_ADR_STAT 8'h04
`define WDTSM_ADR_IEN 8'h08
`define WDTSM_ADR_ICLR 8'h0c
`define WDTSM_ADR_CNT 8'h10
// ==========================================
// field positions
`define WDTSM_CTRL_SWEN 0
`define WDTSM_CTRL_PS_LO 1
`define WDTSM_CTRL_PS_HI 5
`define WDTSM_EV_TIMEOUT 0
`define WDTSM_EV_WAKE 1
`define WDTSM_EV_W 2
`define WDTSM_ZERO32 32'h0000_0000
`endif

/* verilog/wdtsm_pkg.sv */
`default_nettype none
package wdtsm_pkg;
  typedef enum logic [1:0] {
    WDTSM_AWAKE,
    WDTSM_ASLEEP,
    WDTSM_HOLD
  } wdtsm_state_e;
  typedef logic [18:0] wdtsm_cnt_t;
endpackage : wdtsm_pkg
`default_nettype wire

/* verilog/wdtsm_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module wdtsm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // ==========================================
  // two-flop synchroniser
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : wdtsm_sync
`default_nettype wire

/* verilog/wdtsm_top.sv */
// Behaviour
// - counter reaching selected period while awake issues a system reset
// - counter advances on a 1 ms base tick from the slow time base
// - enable code 11: always active, also during sleep
// - enable code 10: active awake, disabled asleep
// - enable code 01: software enable bit decides, awake or asleep
// - enable code 00: always disabled, software enable ignored
// - period select, control bits 5 to 1, picks 1 ms to 256 s
// - reset restores period select to the two second code
// - counter cleared on reset, clear instruction, sleep entry, wake, oscillator fail
// - counter held cleared while disabled
// - after sleep exit counter held clear while start-up timer runs
// - clock switches and divider changes leave the counter alone
// - enabled in sleep: counting restarts from zero after entry clear
// - timeout asleep wakes without reset and updates status flags
// - each code is a power-of-two prescale, code 01010 is one second
`timescale 1ns/1ps
`default_nettype none
`include "wdtsm_consts.svh"
module wdtsm_top #(
  parameter int TICK_CYCLES = `WDTSM_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] cfg_enable_i,
  input wire logic clear_instr_i,
  input wire logic sleep_i,
  input wire logic osc_fail_i,
  input wire logic ost_running_i,
  output logic wdt_reset_o,
  output logic wake_o,
  output logic irq_o,
  output logic timeout_n_o,
  output logic powerdown_n_o
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  // ==========================================
  // period decode
  function automatic wdtsm_pkg::wdtsm_cnt_t wdtsm_limit(input logic [`WDTSM_PS_W-1:0] code);
    if (code > `WDTSM_PS_MAX) begin
      wdtsm_limit = `WDTSM_CNT_ONE;
    end else begin
      wdtsm_limit = `WDTSM_CNT_ONE << code;
    end
  endfunction : wdtsm_limit

  // ==========================================
  // input synchronisers
  logic [1:0] cfg_s;
  logic osc_fail_s;
  logic ost_s;
  wdtsm_sync #(
    .W(4)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({cfg_enable_i, osc_fail_i, ost_running_i}),
    .sync_out({cfg_s, osc_fail_s, ost_s})
  );

  // ==========================================
  // registers
  logic [`WDTSM_PS_W-1:0] ps_reg;
  logic swen_reg;
  logic [`WDTSM_EV_W-1:0] ist_reg;
  logic [`WDTSM_EV_W-1:0] ist_next;
  logic [`WDTSM_EV_W-1:0] ien_reg;
  logic [`WDTSM_EV_W-1:0] ev;
  logic [`WDTSM_EV_W-1:0] iclr;
  logic wr_fire;
  logic rd_sel_ctrl;

  // ==========================================
  // sleep tracking
  wdtsm_pkg::wdtsm_state_e state_reg;
  logic sleep_q;
  logic sleep_enter;
  logic sleep_exit;
  logic asleep;

  assign sleep_enter = sleep_i & ~sleep_q;
  assign sleep_exit = ~sleep_i & sleep_q;
  assign asleep = (state_reg == wdtsm_pkg::WDTSM_ASLEEP);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_i;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= wdtsm_pkg::WDTSM_AWAKE;
    end else begin
      case (state_reg)
        wdtsm_pkg::WDTSM_AWAKE: begin
          if (sleep_enter) begin
            state_reg <= wdtsm_pkg::WDTSM_ASLEEP;
          end
        end
        wdtsm_pkg::WDTSM_ASLEEP: begin
          if (sleep_exit) begin
            state_reg <= wdtsm_pkg::WDTSM_HOLD;
          end
        end
        wdtsm_pkg::WDTSM_HOLD: begin
          if (sleep_enter) begin
            state_reg <= wdtsm_pkg::WDTSM_ASLEEP;
          end else if (!ost_s) begin
            state_reg <= wdtsm_pkg::WDTSM_AWAKE;
          end
        end
        default: begin
          state_reg <= wdtsm_pkg::WDTSM_AWAKE;
        end
      endcase
    end
  end

  // ==========================================
  // operating mode
  logic active;
  always_comb begin
    case (cfg_s)
      `WDTSM_CFG_ALWAYS: active = 1'b1;
      `WDTSM_CFG_NOSLEEP: active = ~asleep;
      `WDTSM_CFG_SOFT: active = swen_reg;
      default: active = 1'b0;
    endcase
  end

  // ==========================================
  // clear conditions
  logic clr;
  assign clr = ~active | clear_instr_i | sleep_enter | sleep_exit | osc_fail_s
    | (state_reg == wdtsm_pkg::WDTSM_HOLD);

  // ==========================================
  // base tick divider, free of any system clock switch
  logic [TW-1:0] tick_cnt_reg;
  logic tick;
  assign tick = (tick_cnt_reg == TICK_LAST);

  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TW'(1);
    end
  end

  // ==========================================
  // watchdog counter
  wdtsm_pkg::wdtsm_cnt_t cnt_reg;
  wdtsm_pkg::wdtsm_cnt_t lim;
  logic hit;
  assign lim = wdtsm_limit(ps_reg);
  assign hit = ~clr & tick & (cnt_reg == lim - `WDTSM_CNT_ONE);

  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      cnt_reg <= `WDTSM_CNT_ZERO;
    end else if (hit) begin
      cnt_reg <= `WDTSM_CNT_ZERO;
    end else if (tick) begin
      cnt_reg <= cnt_reg + `WDTSM_CNT_ONE;
    end
  end

  // ==========================================
  // timeout reset and wake
  logic [2:0] rst_cnt_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdt_reset_o <= 1'b0;
      rst_cnt_reg <= 3'h0;
    end else if (hit && !asleep) begin
      wdt_reset_o <= 1'b1;
      rst_cnt_reg <= `WDTSM_RST_CYCLES - 3'h1;
    end else if (rst_cnt_reg != 3'h0) begin
      rst_cnt_reg <= rst_cnt_reg - 3'h1;
    end else begin
      wdt_reset_o <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= hit & asleep;
    end
  end

  // ==========================================
  // status flags, active low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timeout_n_o <= 1'b1;
      powerdown_n_o <= 1'b1;
    end else if (hit) begin
      timeout_n_o <= 1'b0;
      powerdown_n_o <= ~asleep;
    end else if (clear_instr_i) begin
      timeout_n_o <= 1'b1;
      powerdown_n_o <= 1'b1;
    end else if (sleep_enter) begin
      timeout_n_o <= 1'b1;
      powerdown_n_o <= 1'b0;
    end
  end

  // ==========================================
  // wishbone slave
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  assign wr_fire = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
  assign rd_sel_ctrl = (wb_adr_i == `WDTSM_ADR_CTRL);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ps_reg <= `WDTSM_PS_RESET;
      swen_reg <= `WDTSM_SWEN_RESET;
    end else if (wr_fire && rd_sel_ctrl) begin
      ps_reg <= wb_dat_i[`WDTSM_CTRL_PS_HI:`WDTSM_CTRL_PS_LO];
      swen_reg <= wb_dat_i[`WDTSM_CTRL_SWEN];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ien_reg <= '0;
    end else if (wr_fire && wb_adr_i == `WDTSM_ADR_IEN) begin
      ien_reg <= wb_dat_i[`WDTSM_EV_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_dat_o <= `WDTSM_ZERO32;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      case (wb_adr_i)
        `WDTSM_ADR_CTRL: wb_dat_o <= {26'h000_0000, ps_reg, swen_reg};
        `WDTSM_ADR_STAT: wb_dat_o <= {26'h000_0000, asleep, active, powerdown_n_o, timeout_n_o, ist_reg};
        `WDTSM_ADR_IEN: wb_dat_o <= {30'h0000_0000, ien_reg};
        `WDTSM_ADR_CNT: wb_dat_o <= {13'h0000, cnt_reg};
        default: wb_dat_o <= `WDTSM_ZERO32;
      endcase
    end
  end

  // ==========================================
  // interrupts, set wins over clear
  always_comb begin
    ev = '0;
    ev[`WDTSM_EV_TIMEOUT] = hit & ~asleep;
    ev[`WDTSM_EV_WAKE] = hit & asleep;
    iclr = '0;
    if (wr_fire && wb_adr_i == `WDTSM_ADR_ICLR) begin
      iclr = wb_dat_i[`WDTSM_EV_W-1:0];
    end
    ist_next = (ist_reg & ~iclr) | ev;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ist_reg <= '0;
      irq_o <= 1'b0;
    end else begin
      ist_reg <= ist_next;
      irq_o <= |(ist_next & ien_reg);
    end
  end

  // ==========================================
  // assertions
  reset_on_timeout_a: assert property (@(posedge clk) disable iff (!rst_n)
    hit && !asleep |=> wdt_reset_o && !wake_o ##1 wdt_reset_o ##1 wdt_reset_o ##1 wdt_reset_o)
    else $error("timeout while awake gave no reset pulse");

  tick_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick && !clr |=> tick_cnt_reg == '0 && !tick)
    else $error("base tick divider did not restart");

  always_on_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_s == `WDTSM_CFG_ALWAYS |-> active)
    else $error("always-on mode not active");

  off_in_sleep_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_s == `WDTSM_CFG_NOSLEEP |-> active == !asleep)
    else $error("off-in-sleep mode wrong");

  soft_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_s == `WDTSM_CFG_SOFT |-> active == swen_reg)
    else $error("software mode ignores enable bit");

  held_disabled_a: assert property (@(posedge clk) disable iff (!rst_n)
    !active |=> cnt_reg == `WDTSM_CNT_ZERO && !wdt_reset_o || $past(wdt_reset_o))
    else $error("counter moved while disabled");

  period_one_s_a: assert property (@(posedge clk) disable iff (!rst_n)
    ps_reg == 5'h0a |-> lim == 19'h0_0400)
    else $error("one second code wrong");

  reset_default_a: assert property (@(posedge clk)
    !rst_n |=> ps_reg == `WDTSM_PS_RESET && !swen_reg)
    else $error("period select not restored by reset");

  clear_instr_a: assert property (@(posedge clk) disable iff (!rst_n)
    clear_instr_i || sleep_enter |=> cnt_reg == `WDTSM_CNT_ZERO && timeout_n_o)
    else $error("clear event did not clear counter");

  exit_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_exit |=> cnt_reg == `WDTSM_CNT_ZERO && state_reg == wdtsm_pkg::WDTSM_HOLD)
    else $error("sleep exit did not clear and hold counter");

  ost_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == wdtsm_pkg::WDTSM_HOLD |=> cnt_reg == `WDTSM_CNT_ZERO)
    else $error("counter ran during start-up hold");

  sleep_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    asleep && tick && !clr && !hit |=> cnt_reg == $past(cnt_reg) + `WDTSM_CNT_ONE)
    else $error("counter stalled during sleep");

  sleep_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    hit && asleep |=> wake_o && !wdt_reset_o && !timeout_n_o && !powerdown_n_o)
    else $error("sleep timeout did not wake cleanly");

  awake_reset_cov: cover property (@(posedge clk) disable iff (!rst_n) hit && !asleep);
  sleep_wake_cov: cover property (@(posedge clk) disable iff (!rst_n) hit && asleep);
  ost_hold_cov: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == wdtsm_pkg::WDTSM_HOLD && ost_s);
  irq_cov: cover property (@(posedge clk) disable iff (!rst_n) irq_o);

endmodule : wdtsm_top
`default_nettype wire

/* testbench/wdtsm_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// core model: clear and sleep events
module wdtsm_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic [3:0] kick_gap,
  input wire logic sleep_req,
  input wire logic wake,
  output logic clear_instr,
  output logic sleep
);
  logic [3:0] gap_reg;
  logic woke_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap_reg <= 4'h0;
      clear_instr <= 1'h0;
    end else begin
      gap_reg <= (gap_reg >= kick_gap) ? 4'h0 : gap_reg + 4'h1;
      clear_instr <= hold | (kick_gap != 4'h0 && gap_reg == 4'h0);
    end
  end
  // core leaves sleep on a wake pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      woke_reg <= 1'h0;
      sleep <= 1'h0;
    end else begin
      woke_reg <= sleep_req & (woke_reg | wake);
      sleep <= sleep_req & ~woke_reg & ~wake;
    end
  end
endmodule : wdtsm_core_model
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wdtsm_consts.svh"
module tb;
  localparam int T = 8;
  logic clk, rst_n, cyc, stb, we, ack, clear_instr, sleep, osc_fail, oscillator_startup_timer, hold, sleep_req;
  logic wdt_rst, wake, irq, to_n, pd_n, rst_q, slp_q;
  logic [7:0] adr;
  logic [3:0] sel, kick_gap;
  logic [31:0] dat, rd;
  logic [1:0] cfg;
  logic [4:0] codes[6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h0a, 5'h13};
  int mismatches, n_compared, since, width, evn;
  logic [31:0] exp_rd[$];
  int exp_k[$];
  int exp_t[$];
  wdtsm_top #(.TICK_CYCLES(T)) u_wdtsm_top (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .cfg_enable_i(cfg), .clear_instr_i(clear_instr), .sleep_i(sleep), .osc_fail_i(osc_fail),
    .ost_running_i(oscillator_startup_timer), .wdt_reset_o(wdt_rst), .wake_o(wake), .irq_o(irq), .timeout_n_o(to_n),
    .powerdown_n_o(pd_n));
  wdtsm_core_model u_wdtsm_core_model (.clk(clk), .rst_n(rst_n), .hold(hold), .kick_gap(kick_gap),
    .sleep_req(sleep_req), .wake(wake), .clear_instr(clear_instr), .sleep(sleep));
  // ==========================================
  // compare tasks
  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error read data expected %h seen %h", e, g);
    end
  endtask : cmp_rd
  task automatic cmp_lv(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_lv
  task automatic cmp_ev(input string nm, input int e, input int g, input int tol);
    n_compared++;
    if (g < e - tol || g > e + tol) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask : cmp_ev
  task automatic conclude();
    if (exp_k.size() != 0 || exp_rd.size() != 0) mismatches++;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  // ==========================================
  // bus and scenario tasks
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
    end while (ack !== 1'h1);
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask : wb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    wb(1'h0, a, 32'h0000_0000);
  endtask : rd_chk
  function automatic int per(input logic [4:0] c);
    return (c > `WDTSM_PS_MAX) ? T : T << c;
  endfunction : per
  task automatic run(input logic [1:0] c, input logic sw, input logic s, input logic [4:0] code, input int k);
    int n, e0;
    n = 0;
    hold <= 1'h1;
    cfg <= c;
    wb(1'h1, `WDTSM_ADR_CTRL, {26'h000_0000, code, sw});
    repeat (4) @(posedge clk);
    if (k != 0) begin
      exp_k.push_back(k);
      exp_t.push_back(per(code));
    end
    e0 = evn;
    sleep_req <= s;
    hold <= 1'h0;
    while (evn == e0 && n < per(code) + 60) begin
      @(posedge clk);
      n++;
    end
    if (k != 0) begin
      repeat (2) @(posedge clk);
      cmp_lv("timeout flag", 1'h0, to_n);
      cmp_lv("powerdown flag", k == 1, pd_n);
    end
    hold <= 1'h1;
    sleep_req <= 1'h0;
    repeat (6) @(posedge clk);
    cmp_lv("timeout flag", 1'h1, to_n);
  endtask : run
  // ==========================================
  // result monitor
  always @(posedge clk) begin
    if (clear_instr || sleep != slp_q || osc_fail || oscillator_startup_timer) since = 0;
    else since++;
    slp_q = sleep;
    if (ack === 1'h1 && we === 1'h0 && exp_rd.size() > 0) cmp_rd(exp_rd.pop_front(), rd);
    if ((wdt_rst === 1'h1 && rst_q !== 1'h1) || wake === 1'h1) begin
      evn++;
      if (exp_k.size() == 0) cmp_ev("event", 0, 1, 0);
      else begin
        cmp_ev("event kind", exp_k.pop_front(), (wake === 1'h1) ? 2 : 1, 0);
        cmp_ev("event time", exp_t.pop_front(), since, 5);
      end
    end
    if (wdt_rst === 1'h1) width++;
    else if (rst_q === 1'h1) begin
      cmp_ev("reset width", 4, width, 0);
      width = 0;
    end
    rst_q = wdt_rst;
  end
  // ==========================================
  // clock, watchdog, main sequence
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial begin
    {rst_n, cyc, stb, we, osc_fail, oscillator_startup_timer, sleep_req, rst_q, slp_q} = 9'h000;
    {adr, sel, kick_gap, dat, cfg} = 50'h0;
    hold = 1'h1;
    void'($urandom(32'h535fee95));
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd_chk(`WDTSM_ADR_CTRL, 32'h0000_0016);
    rd_chk(`WDTSM_ADR_STAT, 32'h0000_000c);
    rd_chk(8'h14, 32'h0000_0000);
    run(2'h0, 1'h1, 1'h0, 5'h01, 0);
    run(2'h1, 1'h0, 1'h0, 5'h01, 0);
    rd_chk(`WDTSM_ADR_CNT, 32'h0000_0000);
    foreach (codes[i]) run(2'h3, 1'h0, 1'h0, codes[i], 1);
    run(2'h2, 1'h0, 1'h0, 5'h01, 1);
    run(2'h1, 1'h1, 1'h0, 5'h01, 1);
    wb(1'h1, `WDTSM_ADR_IEN, 32'h0000_0001);
    @(posedge clk);
    cmp_lv("irq", 1'h1, irq);
    rd_chk(`WDTSM_ADR_STAT, 32'h0000_001d);
    wb(1'h1, `WDTSM_ADR_STAT, 32'h0000_00ff);
    wb(1'h1, `WDTSM_ADR_IEN, 32'h0000_0000);
    @(posedge clk);
    cmp_lv("irq", 1'h0, irq);
    wb(1'h1, `WDTSM_ADR_ICLR, 32'h0000_0003);
    rd_chk(`WDTSM_ADR_STAT, 32'h0000_001c);
    rd_chk(`WDTSM_ADR_ICLR, 32'h0000_0000);
    wb(1'h1, `WDTSM_ADR_IEN, 32'h0000_0003);
    @(posedge clk);
    cmp_lv("irq", 1'h0, irq);
    run(2'h3, 1'h0, 1'h1, 5'h01, 2);
    run(2'h2, 1'h0, 1'h1, 5'h01, 0);
    run(2'h1, 1'h1, 1'h1, 5'h01, 2);
    cmp_lv("irq", 1'h1, irq);
    cfg <= 2'h3;
    wb(1'h1, `WDTSM_ADR_CTRL, 32'h0000_0004);
    kick_gap <= 4'($urandom_range(15, 1));
    hold <= 1'h0;
    repeat (200) @(posedge clk);
    kick_gap <= 4'h0;
    run(2'h3, 1'h0, 1'h0, 5'h02, 1);
    osc_fail <= 1'h1;
    run(2'h3, 1'h0, 1'h0, 5'h01, 0);
    osc_fail <= 1'h0;
    sleep_req <= 1'h1;
    oscillator_startup_timer <= 1'h1;
    repeat (4) @(posedge clk);
    run(2'h3, 1'h0, 1'h0, 5'h01, 0);
    rd_chk(`WDTSM_ADR_CNT, 32'h0000_0000);
    oscillator_startup_timer <= 1'h0;
    run(2'h3, 1'h0, 1'h0, 5'h01, 1);
    conclude();
  end
endmodule : tb
`default_nettype wire
